// ### logic/clpu_top.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "clpu_cfg.svh"
// Overview of operation
// - activate after all-low lasts start delay
// - maximum timer bounds high-current start-up
// - hold output at least minimum time unless overcurrent, max expiry or block releases it
// - minimum time acts as reclaim window
// - high starts max timer; mid ends start-up
// - nonzero minimum time extends output after start-up
// - short low period never activates; restarts
// - zero start delay activates immediately
// - overcurrent releases output at once
// - high until max expiry releases output
// - mid current, no inrush: release after minimum
// - inrush during minimum: hold until max/end
// - on/off events, polarity-filtered, timestamped
// - clearable activation and block counters
// - twelve-record ring, oldest overwritten
// - record holds time, event, currents, timers
// - all low, all high, any over
// - 97 percent dropout hysteresis
// - block gives blocked state or release
// - magnitudes refreshed on 5 ms base
module clpu_top #(
  parameter int TICK_DIV = `CLPU_CLK_HZ / 1000 * `CLPU_STEP_MS,
  parameter int LOG_DEPTH = `CLPU_LOG_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // measured magnitudes, same clock domain
  input wire clpu_pkg::clpu_cur_t cur_a,
  input wire clpu_pkg::clpu_cur_t cur_b,
  input wire clpu_pkg::clpu_cur_t cur_c,
  // block input from pin
  input wire logic block_in,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // function outputs
  output logic pickup_active,
  output logic pickup_blocked,
  output logic [5:0] pickup_event_block,
  output logic event_valid
);
  localparam logic [18:0] TSET_RST = 19'(`CLPU_TSET_MS / `CLPU_STEP_MS);
  localparam logic [18:0] TMAX_RST = 19'(`CLPU_TMAX_MS / `CLPU_STEP_MS);
  localparam logic [18:0] TMIN_RST = 19'(`CLPU_TMIN_MS / `CLPU_STEP_MS);
  localparam logic [18:0] TLIM = 19'(`CLPU_MAX_MS / `CLPU_STEP_MS);

  clpu_cmp_if cmp ();

  // protection tick divider
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 32'(TICK_DIV - 1));
      div_q <= (div_q == 32'(TICK_DIV - 1)) ? 32'h0 : div_q + 32'h1;
    end
  end

  // block input synchroniser: change taken when stages two and three agree
  logic blk_s1_q, blk_s2_q, blk_s3_q, blk_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
      blk_s3_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      blk_s1_q <= block_in;
      blk_s2_q <= blk_s1_q;
      blk_s3_q <= blk_s2_q;
      if (blk_s2_q == blk_s3_q) blk_q <= blk_s3_q;
    end
  end

  // settings registers
  logic [31:0] ctrl_q, evmask_q;
  clpu_pkg::clpu_tick_t tset_q, tmax_q, tmin_q;
  clpu_pkg::clpu_cur_t ilow_q, ihigh_q, iover_q;
  // clamp settings to 1800 s worth of ticks
  function automatic clpu_pkg::clpu_tick_t clamp_t(input logic [31:0] v);
    clamp_t = (v > 32'(TLIM)) ? TLIM : v[18:0];
  endfunction : clamp_t

  wire wr_ctrl = reg_wr && reg_addr == `CLPU_REG_CTRL;
  wire clr_cnt = wr_ctrl && reg_wdata[`CLPU_CTRL_CLRCNT];
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= 32'h0;
      evmask_q <= 32'h00000fff;
      tset_q <= TSET_RST;
      tmax_q <= TMAX_RST;
      tmin_q <= TMIN_RST;
      ilow_q <= `CLPU_ILOW_RST;
      ihigh_q <= `CLPU_IHIGH_RST;
      iover_q <= `CLPU_IOVER_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `CLPU_REG_CTRL: ctrl_q <= {reg_wdata[31:1], 1'b0};
        `CLPU_REG_TSET: tset_q <= clamp_t(reg_wdata);
        `CLPU_REG_TMAX: tmax_q <= clamp_t(reg_wdata);
        `CLPU_REG_TMIN: tmin_q <= clamp_t(reg_wdata);
        `CLPU_REG_ILOW: ilow_q <= reg_wdata[15:0];
        `CLPU_REG_IHIGH: ihigh_q <= reg_wdata[15:0];
        `CLPU_REG_IOVER: iover_q <= reg_wdata[15:0];
        `CLPU_REG_EVMASK: evmask_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  clpu_level u_level (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .upd(tick_q),
    .cur_a(cur_a),
    .cur_b(cur_b),
    .cur_c(cur_c),
    .th_low(ilow_q),
    .th_high(ihigh_q),
    .th_over(iover_q),
    .cmp(cmp)
  );

  // sequencer; timers advance only on ticks
  clpu_pkg::clpu_state_e st_q;
  clpu_pkg::clpu_tick_t tlow_q, tmx_q, tmn_q, tact_q, tsu_q;
  logic inrush_q, su_end_q;
  wire lo = cmp.all_low;
  wire hi = cmp.all_high;
  wire ov = cmp.any_over;
  wire mid = !lo && !hi;
  wire min_done = (tmn_q >= tmin_q);
  wire max_done = (tmx_q >= tmax_q);
  // release paths
  wire rel_over = ov;
  wire rel_max = inrush_q && hi && max_done;
  // release needs mid current: a feeder still at low load keeps the output
  wire rel_min = min_done && (!inrush_q || su_end_q) && mid;
  wire low_done = (tset_q == 19'h0) || (tlow_q >= tset_q);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q <= clpu_pkg::CLPU_ST_NORMAL;
      tlow_q <= 19'h0;
      tmx_q <= 19'h0;
      tmn_q <= 19'h0;
      tact_q <= 19'h0;
      tsu_q <= 19'h0;
      inrush_q <= 1'b0;
      su_end_q <= 1'b0;
    end else begin
      case (st_q)
        clpu_pkg::CLPU_ST_NORMAL, clpu_pkg::CLPU_ST_LOWWAIT: begin
          if (!lo) begin
            st_q <= clpu_pkg::CLPU_ST_NORMAL;
            tlow_q <= 19'h0;
          end else if (low_done) begin
            st_q <= blk_q ? clpu_pkg::CLPU_ST_BLOCKED : clpu_pkg::CLPU_ST_ACTIVE;
            tmx_q <= 19'h0;
            tmn_q <= 19'h0;
            tact_q <= 19'h0;
            tsu_q <= 19'h0;
            inrush_q <= 1'b0;
            su_end_q <= 1'b0;
          end else begin
            st_q <= clpu_pkg::CLPU_ST_LOWWAIT;
            if (tick_q) tlow_q <= tlow_q + 19'h1;
          end
        end
        clpu_pkg::CLPU_ST_ACTIVE: begin
          if (rel_over || rel_max || rel_min || blk_q) begin
            st_q <= clpu_pkg::CLPU_ST_NORMAL;
            tlow_q <= 19'h0;
          end else if (tick_q) begin
            tact_q <= tact_q + 19'h1;
            // minimum window runs only on mid current: reclaim window
            if (mid && !min_done) tmn_q <= tmn_q + 19'h1;
            if (hi) begin
              inrush_q <= 1'b1;
              su_end_q <= 1'b0;
              tmx_q <= tmx_q + 19'h1;
              tsu_q <= tsu_q + 19'h1;
            end else if (inrush_q && mid) begin
              su_end_q <= 1'b1;
              tmx_q <= 19'h0;
            end
          end
        end
        clpu_pkg::CLPU_ST_BLOCKED: begin
          if (!blk_q || !lo) begin
            st_q <= clpu_pkg::CLPU_ST_NORMAL;
            tlow_q <= 19'h0;
          end
        end
        default: st_q <= clpu_pkg::CLPU_ST_NORMAL;
      endcase
    end
  end

  // event sources and edge detection
  wire act = (st_q == clpu_pkg::CLPU_ST_ACTIVE);
  wire blkd = (st_q == clpu_pkg::CLPU_ST_BLOCKED);
  // the block edge precedes the blocked state, so count the step into it
  wire blk_enter = !act && !blkd && lo && low_done && blk_q;
  wire [5:0] lvl = {blk_q, act, ov, mid && !act, act && inrush_q && hi, lo};
  logic [5:0] lvl_q;
  wire [5:0] ev_on = lvl & ~lvl_q;
  wire [5:0] ev_off = ~lvl & lvl_q;
  wire [11:0] ev_sel = {ev_off, ev_on} & evmask_q[11:0];
  logic [31:0] ms_q;
  logic [17:0] msdiv_q;
  logic [11:0] ev_q;
  logic [31:0] ev_time_q;
  logic [15:0] act_cnt_q, blk_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lvl_q <= 6'h04; // idle levels, so no false load-normal edge after reset
      ev_q <= 12'h0;
      ev_time_q <= 32'h0;
      ms_q <= 32'h0;
      msdiv_q <= 18'h0;
      event_valid <= 1'b0;
    end else begin
      lvl_q <= lvl;
      msdiv_q <= (msdiv_q == 18'(`CLPU_CLK_HZ / 1000 - 1)) ? 18'h0 : msdiv_q + 18'h1;
      if (msdiv_q == 18'(`CLPU_CLK_HZ / 1000 - 1)) ms_q <= ms_q + 32'h1;
      event_valid <= |ev_sel;
      if (|ev_sel) begin
        ev_q <= ev_sel;
        ev_time_q <= ms_q;
      end
    end
  end
  // counters; an event in the clear cycle still counts
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      act_cnt_q <= 16'h0;
      blk_cnt_q <= 16'h0;
    end else begin
      act_cnt_q <= (clr_cnt ? 16'h0 : act_cnt_q) + {15'h0, ev_on[4]};
      blk_cnt_q <= (clr_cnt ? 16'h0 : blk_cnt_q) + {15'h0, blk_enter};
    end
  end

  // log ring: 8 words per record
  logic [31:0] log_mem [LOG_DEPTH*8];
  logic [3:0] wp_q;
  logic [6:0] logsel_q;
  wire log_en = |ev_on;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wp_q <= 4'h0;
    end else if (log_en) begin
      wp_q <= (wp_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (log_en) begin
      log_mem[{wp_q, 3'd0}] <= ms_q;
      log_mem[{wp_q, 3'd1}] <= {26'h0, ev_on};
      log_mem[{wp_q, 3'd2}] <= {cur_b, cur_a};
      log_mem[{wp_q, 3'd3}] <= {16'h0, cur_c};
      log_mem[{wp_q, 3'd4}] <= {13'h0, (tset_q > tlow_q) ? tset_q - tlow_q : 19'h0};
      log_mem[{wp_q, 3'd5}] <= {13'h0, tact_q};
      log_mem[{wp_q, 3'd6}] <= {13'h0, tsu_q};
      log_mem[{wp_q, 3'd7}] <= {13'h0, tmn_q[18:0]} | {ctrl_q[7:4], 28'h0};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) logsel_q <= 7'h0;
    else if (reg_wr && reg_addr == `CLPU_REG_LOGSEL) logsel_q <= reg_wdata[6:0];
  end

  // read mux; unmapped reads give zero
  logic [31:0] rd_d;
  always_comb begin
    case (reg_addr)
      `CLPU_REG_CTRL: rd_d = ctrl_q;
      `CLPU_REG_TSET: rd_d = {13'h0, tset_q};
      `CLPU_REG_TMAX: rd_d = {13'h0, tmax_q};
      `CLPU_REG_TMIN: rd_d = {13'h0, tmin_q};
      `CLPU_REG_ILOW: rd_d = {16'h0, ilow_q};
      `CLPU_REG_IHIGH: rd_d = {16'h0, ihigh_q};
      `CLPU_REG_IOVER: rd_d = {16'h0, iover_q};
      `CLPU_REG_STATUS: rd_d = {20'h0, 3'h0, blk_q, inrush_q, su_end_q, lvl[3:0], act, blkd};
      `CLPU_REG_CNT: rd_d = {blk_cnt_q, act_cnt_q};
      `CLPU_REG_EVMASK: rd_d = evmask_q;
      `CLPU_REG_EVENT: rd_d = {20'h0, ev_q};
      `CLPU_REG_LOGPTR: rd_d = {28'h0, wp_q};
      `CLPU_REG_LOGSEL: rd_d = {25'h0, logsel_q};
      `CLPU_REG_LOGDAT: rd_d = (logsel_q < 7'(LOG_DEPTH * 8)) ? log_mem[logsel_q] : 32'h0;
      `CLPU_REG_TIMELO: rd_d = ev_time_q;
      `CLPU_REG_TIMEHI: rd_d = ms_q;
      default: rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_d : 32'h0;
  end

  assign pickup_active = act;
  assign pickup_blocked = blkd;
  assign pickup_event_block = lvl_q;
endmodule : clpu_top

// ### logic/clpu_cfg.svh
`ifndef CLPU_CFG_SVH
`define CLPU_CFG_SVH
// register indexes (word address = index)
`define CLPU_REG_CTRL 8'h00
`define CLPU_REG_TSET 8'h01
`define CLPU_REG_TMAX 8'h02
`define CLPU_REG_TMIN 8'h03
`define CLPU_REG_ILOW 8'h04
`define CLPU_REG_IHIGH 8'h05
`define CLPU_REG_IOVER 8'h06
`define CLPU_REG_STATUS 8'h07
`define CLPU_REG_CNT 8'h08
`define CLPU_REG_EVMASK 8'h09
`define CLPU_REG_EVENT 8'h0a
`define CLPU_REG_LOGPTR 8'h0b
`define CLPU_REG_LOGSEL 8'h0c
`define CLPU_REG_LOGDAT 8'h0d
`define CLPU_REG_TIMELO 8'h0e
`define CLPU_REG_TIMEHI 8'h0f
// ctrl bits
`define CLPU_CTRL_CLRCNT 0
`define CLPU_CTRL_SG_LSB 4
// timing: step 5 ms, defaults in ms
`define CLPU_STEP_MS 5
`define CLPU_TSET_MS 10000
`define CLPU_TMAX_MS 30000
`define CLPU_TMIN_MS 40
`define CLPU_MAX_MS 1800000
// thresholds in 0.01 x In
`define CLPU_ILOW_RST 16'h0014
`define CLPU_IHIGH_RST 16'h0078
`define CLPU_IOVER_RST 16'h00c8
`define CLPU_RESET_PCT 97
`define CLPU_CLK_HZ 250000000
`define CLPU_LOG_DEPTH 12
`endif

// ### logic/clpu_pkg.sv
package clpu_pkg;
  typedef enum logic [2:0] {
    CLPU_ST_NORMAL, CLPU_ST_LOWWAIT, CLPU_ST_ACTIVE, CLPU_ST_BLOCKED
  } clpu_state_e;
  // event bit positions in the event word
  typedef enum logic [2:0] {
    CLPU_EV_LOW, CLPU_EV_HIGH, CLPU_EV_NORMAL, CLPU_EV_OVER, CLPU_EV_ACT, CLPU_EV_BLOCK
  } clpu_event_e;
  typedef logic [15:0] clpu_cur_t;
  typedef logic [18:0] clpu_tick_t;
endpackage : clpu_pkg

// ### logic/clpu_cmp_if.sv
`timescale 1ns/1ps
// comparator results handed from the level stage to the sequencer
interface clpu_cmp_if;
  logic all_low;
  logic all_high;
  logic any_over;
  modport src (output all_low, output all_high, output any_over);
  modport dst (input all_low, input all_high, input any_over);
endinterface : clpu_cmp_if

// ### logic/clpu_level.sv
`timescale 1ns/1ps
`include "clpu_cfg.svh"
// threshold detectors with 97 % dropout hysteresis
module clpu_level (
  // clock
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic upd,
  // magnitudes and settings
  input wire clpu_pkg::clpu_cur_t cur_a,
  input wire clpu_pkg::clpu_cur_t cur_b,
  input wire clpu_pkg::clpu_cur_t cur_c,
  input wire clpu_pkg::clpu_cur_t th_low,
  input wire clpu_pkg::clpu_cur_t th_high,
  input wire clpu_pkg::clpu_cur_t th_over,
  // results
  clpu_cmp_if.src cmp
);
  // 97 % of setting, computed once per threshold
  function automatic clpu_pkg::clpu_cur_t rst_lvl(input clpu_pkg::clpu_cur_t s);
    logic [23:0] p;
    p = 24'(s) * 24'(`CLPU_RESET_PCT);
    rst_lvl = 16'(p / 24'd100);
  endfunction : rst_lvl

  wire [15:0] low_r = rst_lvl(th_low);
  wire [15:0] high_r = rst_lvl(th_high);
  wire [15:0] over_r = rst_lvl(th_over);
  logic low_q, high_q, over_q;
  // low drops out above setting; high/over drop out below 97 %
  wire low_d = low_q ? (cur_a < th_low && cur_b < th_low && cur_c < th_low)
                     : (cur_a < low_r && cur_b < low_r && cur_c < low_r);
  wire high_d = high_q ? (cur_a > high_r && cur_b > high_r && cur_c > high_r)
                       : (cur_a > th_high && cur_b > th_high && cur_c > th_high);
  wire over_d = over_q ? (cur_a > over_r || cur_b > over_r || cur_c > over_r)
                       : (cur_a > th_over || cur_b > th_over || cur_c > th_over);
  // refresh only on the 5 ms measurement tick
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      low_q <= 1'b0;
      high_q <= 1'b0;
      over_q <= 1'b0;
    end else if (upd) begin
      low_q <= low_d;
      high_q <= high_d;
      over_q <= over_d;
    end
  end
  assign cmp.all_low = low_q;
  assign cmp.all_high = high_q;
  assign cmp.any_over = over_q;
endmodule : clpu_level

// ### verif/clpt_top_properties.sv
`timescale 1ns/1ps
// port-level checker for the pickup supervisor; sees only the top ports
module clpt_top_properties #(
  parameter int TICK_DIV = 10,
  parameter int LOG_DEPTH = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // magnitudes and block pin
  input wire clpu_pkg::clpu_cur_t cur_a,
  input wire clpu_pkg::clpu_cur_t cur_b,
  input wire clpu_pkg::clpu_cur_t cur_c,
  input wire logic block_in,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // function outputs
  input wire logic pickup_active,
  input wire logic pickup_blocked,
  input wire logic [5:0] pickup_event_block,
  input wire logic event_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // run length of any phase above the default overcurrent setting
  wire over_now = (cur_a > 16'h00c8) || (cur_b > 16'h00c8) || (cur_c > 16'h00c8);
  logic [7:0] over_cnt_q;
  logic [7:0] over_cnt_d;
  assign over_cnt_d = (over_cnt_q == 8'hff) ? over_cnt_q : over_cnt_q + 8'h01;
  // saturating, so a long fault never wraps back to a short one
  always_ff @(posedge sys_clk) begin
    if (!nrst || !over_now) over_cnt_q <= 8'h00;
    else over_cnt_q <= over_cnt_d;
  end
  // three ticks covers sampling plus comparator latency
  sequence over_long_s;
    32'(over_cnt_q) > 3 * TICK_DIV;
  endsequence
  sequence blk_held_s;
    block_in [*8];
  endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
  rdata_unmapped_a: assert property (
    $past(reg_rd) && $past(reg_addr) > 8'h0f |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  state_excl_a: assert property (
    !(pickup_active && pickup_blocked)) else $error("active and blocked together");
  act_event_a: assert property (
    $rose(pickup_active) |-> ##[0:3] pickup_event_block[4]) else $error("no activation event");
  blk_event_a: assert property (
    $rose(pickup_blocked) |-> ##[0:3] pickup_event_block[5]) else $error("no block event");
  blk_noact_a: assert property (
    blk_held_s |=> !$rose(pickup_active)) else $error("activation while blocked");
  over_release_a: assert property (
    over_long_s |-> !pickup_active) else $error("output held during overcurrent");
  over_flag_a: assert property (
    over_long_s |-> pickup_event_block[3]) else $error("overcurrent event missing");
  ev_pulse_a: assert property (
    event_valid |-> pickup_event_block != $past(pickup_event_block))
    else $error("event pulse without level change");
endmodule : clpt_top_properties

bind clpu_top clpt_top_properties #(.TICK_DIV(TICK_DIV), .LOG_DEPTH(LOG_DEPTH)) u_props (
  .sys_clk, .nrst, .cur_a, .cur_b, .cur_c, .block_in, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .pickup_active, .pickup_blocked, .pickup_event_block, .event_valid
);

// ### verif/tb_cold_load_pickup_timing.sv
`timescale 1ns/1ps
`include "clpu_cfg.svh"
module tb_cold_load_pickup_timing;
  localparam int TDIV = 10;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [3:0] p; logic k;} clpt_exp_s;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  clpu_pkg::clpu_cur_t cur_a = 16'h0032;
  clpu_pkg::clpu_cur_t cur_b = 16'h0032;
  clpu_pkg::clpu_cur_t cur_c = 16'h0032;
  logic block_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pickup_active;
  logic pickup_blocked;
  logic [5:0] pickup_event_block;
  logic event_valid;
  logic rd_seen = 1'b0;
  int failures = 0;
  int check_count = 0;
  clpt_exp_s exp_q[$];
  clpt_exp_s cur_x;
  logic [7:0] dfl_a [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h20};
  logic [31:0] dfl_v [8] = '{`CLPU_TSET_MS / `CLPU_STEP_MS, `CLPU_TMAX_MS / `CLPU_STEP_MS,
    `CLPU_TMIN_MS / `CLPU_STEP_MS, `CLPU_ILOW_RST, `CLPU_IHIGH_RST, `CLPU_IOVER_RST,
    32'hfff, 32'h0};

  // short tick so timer settings stay a few cycles long
  clpu_top #(.TICK_DIV(TDIV)) dut (
    .sys_clk, .nrst, .cur_a, .cur_b, .cur_c, .block_in, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pickup_active, .pickup_blocked, .pickup_event_block, .event_valid
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
  end
  always @(negedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      cur_x = exp_q.pop_front();
      cmp_rd(cur_x, reg_rdata);
      if (cur_x.k) cmp_pin(cur_x.p, {pickup_event_block[5:4], pickup_active, pickup_blocked});
    end
  end

  // pins {block level, activation level, active, blocked}
  task automatic cmp_pin(input logic [3:0] e, input logic [3:0] got);
    check_count++;
    if (got !== e) begin
      failures++;
      $display("unexpected pins t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : cmp_pin

  task automatic cmp_rd(input clpt_exp_s x, input logic [31:0] got);
    check_count++;
    if ((got & x.m) !== (x.e & x.m)) begin
      failures++;
      $display("unexpected t=%0t exp=%h got=%h", $time, x.e & x.m, got & x.m);
    end
  endtask : cmp_rd

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic ticks(input int n);
    repeat (n * TDIV) @(posedge sys_clk);
  endtask : ticks

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [3:0] p, input logic k);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back('{e, m, p, k});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // status bit1 active, bit0 blocked
  task automatic st(input logic [31:0] e);
    rd(`CLPU_REG_STATUS, e, 32'h3, {e[0], e[1], e[1], e[0]}, 1'b1);
  endtask : st

  // all three phases random within one band
  task automatic setc(input int b, input int s);
    @(posedge sys_clk);
    cur_a <= 16'(b + $urandom % s);
    cur_b <= 16'(b + $urandom % s);
    cur_c <= 16'(b + $urandom % s);
  endtask : setc

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h232a));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rd(dfl_a[i], dfl_v[i], 32'hffffffff, 4'h0, 1'b0);
    $display("test defaults done");
    wr(`CLPU_REG_TSET, 32'h6);
    wr(`CLPU_REG_TMIN, 32'h14);
    setc(1, 15);
    ticks(2);
    setc(30, 60);
    ticks(3);
    setc(1, 15);
    ticks(3);
    st(32'h0);
    ticks(6);
    st(32'h2);
    $display("test start delay done");
    setc(30, 60);
    ticks(3);
    st(32'h2);
    ticks(25);
    st(32'h0);
    $display("test minimum hold done");
    setc(1, 15);
    ticks(9);
    st(32'h2);
    setc(30, 60);
    @(posedge sys_clk);
    cur_b <= 16'(210 + $urandom % 90);
    ticks(3);
    st(32'h0);
    setc(30, 60);
    $display("test overcurrent done");
    wr(`CLPU_REG_TMIN, 32'h2);
    wr(`CLPU_REG_TMAX, 32'h5);
    setc(1, 15);
    ticks(9);
    setc(130, 50);
    ticks(3);
    st(32'h2);
    ticks(8);
    st(32'h0);
    setc(30, 60);
    $display("test maximum timer done");
    wr(`CLPU_REG_TSET, 32'h0);
    wr(`CLPU_REG_TMIN, 32'h14);
    ticks(2);
    setc(1, 15);
    ticks(2);
    st(32'h2);
    setc(30, 60);
    ticks(25);
    $display("test zero delay done");
    wr(`CLPU_REG_TSET, 32'h6);
    block_in <= 1'b1;
    ticks(1);
    setc(1, 15);
    ticks(9);
    st(32'h1);
    block_in <= 1'b0;
    setc(30, 60);
    ticks(3);
    $display("test block done");
    rd(`CLPU_REG_CNT, 32'h00010004, 32'hffffffff, 4'h0, 1'b0);
    wr(`CLPU_REG_CTRL, 32'h1);
    rd(`CLPU_REG_CNT, 32'h0, 32'hffffffff, 4'h0, 1'b0);
    $display("test counters done");
    repeat (4) @(posedge sys_clk);
    if (exp_q.size() != 0) failures++;
    summarize();
  end
endmodule : tb_cold_load_pickup_timing
